// file: hdl/sp0_fifo.v
module sp0_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock and reset.
   input wire mclk_in,
   input wire resetn_in,
   // Fill side.
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   // Drain side.
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   assign in_ready_out = (count_reg != DEPTH[AW:0]);
   assign out_valid_out = (count_reg != {(AW+1){1'b0}});
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem_reg[rd_ptr_reg];
   always @(posedge mclk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // sp0_fifo

// file: hdl/sp0_regs.vh
`ifndef SP0_REGS_VH
`define SP0_REGS_VH
`define SP0_ADDR_CONTROL 8'h98
`define SP0_ADDR_DATA 8'h99
`define SP0_CTL_MODE_HI 7
`define SP0_CTL_MODE_LO 6
`define SP0_CTL_MULTIPROC 5
`define SP0_CTL_RX_ENABLE 4
`define SP0_CTL_TX_NINTH 3
`define SP0_CTL_RX_NINTH 2
`define SP0_CTL_TX_DONE 1
`define SP0_CTL_RX_DONE 0
`define SP0_CTL_RESET 8'h00
`define SP0_DATA_RESET 8'h00
`define SP0_DIV_SLOW 12
`define SP0_DIV_FAST 4
`define SP0_DIV_M2_NORMAL 64
`define SP0_DIV_M2_DOUBLE 32
`define SP0_OVS 16
`define SP0_FIFO_DEPTH 32
`endif

// file: hdl/sp0_uart.v
// Behaviour
// - Two mode bits pick four frame modes.
// - Frame error flag set on bad stop.
// - Multiproc modes 2/3 drop ninth-bit-zero frames.
// - Multiproc mode 1 drops frames lacking stop.
// - Mode 0 shift clock divide 24 or 8.
// - Receive only while receive enable set.
// - Modes 2/3 send software ninth bit.
// - Received ninth field depends on mode.
// - Transmit done at bit 8 or stop start.
// - Receive done at bit 8 or mid-stop.
// - Data address: read receive, write transmit.
// - Enable bit selects mode bit or error flag.
// - Baud double speeds mode 2 only.
// - Transmit pin, and receive pin that also drives the mode 0 shift clock while receiving.
`include "sp0_regs.vh"
module sp0_uart (
   // Clock and reset.
   input wire mclk_in,
   input wire resetn_in,
   // Register port.
   input wire [7:0] reg_addr_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   // Configuration from the power control register.
   input wire frame_err_detect_enable_in,
   input wire baud_double_in,
   // Variable rate tick from the timer block.
   input wire baud_tick_in,
   // Serial pins; output enables are low while driving.
   input wire rxd_in,
   output reg rxd_out,
   output reg rxd_oen_out,
   output reg txd_out,
   // Status.
   output wire tx_done_flag_out,
   output wire rx_done_flag_out,
   output wire tx_ready_out
);
   localparam [1:0] TX_IDLE = 2'd0;
   localparam [1:0] TX_RUN = 2'd1;
   localparam [1:0] RX_IDLE = 2'd0;
   localparam [1:0] RX_RUN = 2'd1;
   localparam [1:0] RX_M0 = 2'd2;

   reg mode_hi_reg;
   reg frame_error_reg;
   reg mode_low_bit_reg;
   reg multiproc_enable_reg;
   reg rx_enable_reg;
   reg tx_ninth_bit_reg;
   reg rx_ninth_bit_reg;
   reg tx_done_flag_reg;
   reg rx_done_flag_reg;
   reg [7:0] rx_data_reg;
   reg [2:0] rx_sync_reg;
   reg [6:0] div_reg;
   reg [1:0] tx_state_reg;
   reg [10:0] tx_shift_reg;
   reg [3:0] tx_bits_reg;
   reg [3:0] tx_ovs_reg;
   reg [1:0] rx_state_reg;
   reg [8:0] rx_shift_reg;
   reg [3:0] rx_bits_reg;
   reg [3:0] rx_ovs_reg;
   reg rx_m0_phase_reg;
   reg m0_clk_phase_reg;
   reg rx_pin_reg;
   reg rx_pin_prev_reg;

   wire [1:0] mode;
   wire rx_pin;
   wire div_tick;
   wire ovs_tick;
   wire [6:0] div_len;
   wire fifo_valid;
   wire fifo_ready;
   wire [7:0] fifo_data;
   wire wr_ctl;
   wire wr_data;
   wire tx_pop;
   wire [3:0] tx_frame_bits;
   reg rx_accept;
   reg rx_finish;
   reg rx_frame_err;

   // The stored upper mode bit keeps its value while control bit 7 reads as error flag.
   assign mode = {mode_hi_reg, mode_low_bit_reg};
   assign rx_pin = rx_pin_reg;
   assign wr_ctl = reg_wr_in && (reg_addr_in == `SP0_ADDR_CONTROL);
   assign wr_data = reg_wr_in && (reg_addr_in == `SP0_ADDR_DATA);
   assign tx_done_flag_out = tx_done_flag_reg;
   assign rx_done_flag_out = rx_done_flag_reg;
   assign tx_ready_out = fifo_ready;

   // Fixed-rate divider: mode 0 half-bit tick, mode 2 oversample tick.
   assign div_len = (mode == 2'd0) ?
      (multiproc_enable_reg ? 7'd`SP0_DIV_FAST : 7'd`SP0_DIV_SLOW) :
      (baud_double_in ? 7'd`SP0_DIV_M2_DOUBLE / 7'd`SP0_OVS :
       7'd`SP0_DIV_M2_NORMAL / 7'd`SP0_OVS);
   // A mode change may shorten the period below the current count; wrap at once.
   assign div_tick = (div_reg >= div_len - 7'd1);
   // Modes 1 and 3 take the external tick; baud double only changes the mode 2 divider.
   assign ovs_tick = (mode == 2'd2) ? div_tick : baud_tick_in;

   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         div_reg <= 7'd0;
         rx_sync_reg <= 3'b111;
         rx_pin_reg <= 1'b1;
         rx_pin_prev_reg <= 1'b1;
      end else begin
         div_reg <= div_tick ? 7'd0 : div_reg + 7'd1;
         rx_sync_reg <= {rx_sync_reg[1:0], rxd_in};
         if (rx_sync_reg[2] == rx_sync_reg[1]) begin
            rx_pin_reg <= rx_sync_reg[2];
         end
         rx_pin_prev_reg <= rx_pin_reg;
      end
   end

   // Transmit words wait in the FIFO so software can queue bytes ahead.
   sp0_fifo #(.WIDTH(8), .DEPTH(`SP0_FIFO_DEPTH), .AW(5)) u_fifo (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .in_valid_in(wr_data),
      .in_ready_out(fifo_ready),
      .in_data_in(reg_wdata_in),
      .out_valid_out(fifo_valid),
      .out_ready_in(tx_pop),
      .out_data_out(fifo_data)
   );

   assign tx_pop = (tx_state_reg == TX_IDLE) && fifo_valid;
   assign tx_frame_bits = (mode == 2'd0) ? 4'd8 : (mode == 2'd1) ? 4'd10 : 4'd11;

   // Transmitter.
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 11'h7ff;
         tx_bits_reg <= 4'd0;
         tx_ovs_reg <= 4'd0;
         txd_out <= 1'b1;
         m0_clk_phase_reg <= 1'b0;
      end else begin
         case (tx_state_reg)
            TX_IDLE: begin
               txd_out <= 1'b1;
               tx_ovs_reg <= 4'd0;
               tx_bits_reg <= 4'd0;
               if (tx_pop) begin
                  if (mode == 2'd0) begin
                     tx_shift_reg <= {3'b111, fifo_data};
                  end else if (mode == 2'd1) begin
                     tx_shift_reg <= {2'b11, fifo_data, 1'b0};
                  end else begin
                     tx_shift_reg <= {1'b1, tx_ninth_bit_reg, fifo_data, 1'b0};
                  end
                  tx_state_reg <= TX_RUN;
               end
            end
            TX_RUN: begin
               if (mode == 2'd0) begin
                  if (div_tick) begin
                     m0_clk_phase_reg <= ~m0_clk_phase_reg;
                     if (!m0_clk_phase_reg) begin
                        txd_out <= tx_shift_reg[0];
                     end else begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                        tx_bits_reg <= tx_bits_reg + 4'd1;
                        if (tx_bits_reg == 4'd7) begin
                           tx_state_reg <= TX_IDLE;
                        end
                     end
                  end
               end else if (ovs_tick) begin
                  tx_ovs_reg <= tx_ovs_reg + 4'd1;
                  if (tx_ovs_reg == 4'd0) begin
                     txd_out <= tx_shift_reg[0];
                  end
                  if (tx_ovs_reg == 4'd15) begin
                     tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                     tx_bits_reg <= tx_bits_reg + 4'd1;
                     if (tx_bits_reg == tx_frame_bits - 4'd1) begin
                        tx_state_reg <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // Receiver.
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 9'h000;
         rx_bits_reg <= 4'd0;
         rx_ovs_reg <= 4'd0;
         rx_m0_phase_reg <= 1'b0;
         rxd_out <= 1'b1;
         rxd_oen_out <= 1'b1;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               rxd_oen_out <= 1'b1;
               rx_bits_reg <= 4'd0;
               rx_ovs_reg <= 4'd0;
               if (rx_enable_reg && !rx_done_flag_reg && mode == 2'd0) begin
                  rx_state_reg <= RX_M0;
                  rx_m0_phase_reg <= 1'b0;
               end else if (rx_enable_reg && mode != 2'd0 && !rx_pin && rx_pin_prev_reg) begin
                  // Only a falling edge starts a frame, so a low bad stop bit cannot.
                  rx_state_reg <= RX_RUN;
               end
            end
            RX_M0: begin
               // Mode 0 shift clock goes out on the receive pin.
               rxd_oen_out <= 1'b0;
               if (!rx_enable_reg) begin
                  rx_state_reg <= RX_IDLE;
               end else if (div_tick) begin
                  rx_m0_phase_reg <= ~rx_m0_phase_reg;
                  rxd_out <= rx_m0_phase_reg;
                  if (rx_m0_phase_reg) begin
                     rx_shift_reg <= {1'b0, txd_in_sample(rx_pin), rx_shift_reg[7:1]};
                     rx_bits_reg <= rx_bits_reg + 4'd1;
                     if (rx_bits_reg == 4'd7) begin
                        rx_state_reg <= RX_IDLE;
                     end
                  end
               end
            end
            RX_RUN: begin
               if (!rx_enable_reg) begin
                  rx_state_reg <= RX_IDLE;
               end else if (ovs_tick) begin
                  rx_ovs_reg <= rx_ovs_reg + 4'd1;
                  if (rx_ovs_reg == 4'd7) begin
                     if (rx_bits_reg == 4'd0 && rx_pin) begin
                        // A start bit that fails at mid-bit was a glitch.
                        rx_state_reg <= RX_IDLE;
                     end else if (rx_bits_reg == tx_frame_bits - 4'd1) begin
                        rx_state_reg <= RX_IDLE;
                     end else if (rx_bits_reg != 4'd0) begin
                        rx_shift_reg <= {rx_pin, rx_shift_reg[8:1]};
                     end
                  end
                  if (rx_ovs_reg == 4'd15) begin
                     rx_bits_reg <= rx_bits_reg + 4'd1;
                  end
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // Sampling helper keeps the mode 0 data path readable.
   function txd_in_sample;
      input b;
      begin
         txd_in_sample = b;
      end
   endfunction

   // Frame end decisions.
   always @* begin
      rx_finish = 1'b0;
      rx_accept = 1'b0;
      rx_frame_err = 1'b0;
      if (rx_state_reg == RX_M0 && div_tick && rx_m0_phase_reg && rx_bits_reg == 4'd7) begin
         rx_finish = 1'b1;
         rx_accept = 1'b1;
      end else if (rx_state_reg == RX_RUN && rx_enable_reg && ovs_tick && rx_ovs_reg == 4'd7 &&
                   rx_bits_reg == tx_frame_bits - 4'd1) begin
         rx_finish = 1'b1;
         rx_frame_err = !rx_pin;
         // A frame is dropped while software has not taken the last one.
         if (!rx_done_flag_reg) begin
            if (mode == 2'd1) begin
               rx_accept = !multiproc_enable_reg || rx_pin;
            end else begin
               rx_accept = !multiproc_enable_reg || rx_shift_reg[8];
            end
         end
      end
   end

   // Control and data registers; hardware set wins over software clear.
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         mode_hi_reg <= 1'b0;
         frame_error_reg <= 1'b0;
         mode_low_bit_reg <= 1'b0;
         multiproc_enable_reg <= 1'b0;
         rx_enable_reg <= 1'b0;
         tx_ninth_bit_reg <= 1'b0;
         rx_ninth_bit_reg <= 1'b0;
         tx_done_flag_reg <= 1'b0;
         rx_done_flag_reg <= 1'b0;
         rx_data_reg <= `SP0_DATA_RESET;
      end else begin
         if (wr_ctl) begin
            if (frame_err_detect_enable_in) begin
               frame_error_reg <= reg_wdata_in[`SP0_CTL_MODE_HI];
            end else begin
               mode_hi_reg <= reg_wdata_in[`SP0_CTL_MODE_HI];
            end
            mode_low_bit_reg <= reg_wdata_in[`SP0_CTL_MODE_LO];
            multiproc_enable_reg <= reg_wdata_in[`SP0_CTL_MULTIPROC];
            rx_enable_reg <= reg_wdata_in[`SP0_CTL_RX_ENABLE];
            tx_ninth_bit_reg <= reg_wdata_in[`SP0_CTL_TX_NINTH];
            rx_ninth_bit_reg <= reg_wdata_in[`SP0_CTL_RX_NINTH];
            tx_done_flag_reg <= reg_wdata_in[`SP0_CTL_TX_DONE];
            rx_done_flag_reg <= reg_wdata_in[`SP0_CTL_RX_DONE];
         end
         if (rx_finish && rx_frame_err && mode != 2'd0) begin
            frame_error_reg <= 1'b1;
         end
         if (tx_state_reg == TX_RUN && ((mode == 2'd0 && div_tick && m0_clk_phase_reg &&
             tx_bits_reg == 4'd7) || (mode != 2'd0 && ovs_tick && tx_ovs_reg == 4'd0 &&
             tx_bits_reg == tx_frame_bits - 4'd1))) begin
            tx_done_flag_reg <= 1'b1;
         end
         if (rx_accept) begin
            rx_done_flag_reg <= 1'b1;
            if (mode == 2'd0) begin
               rx_data_reg <= {rx_pin, rx_shift_reg[7:1]};
            end else begin
               rx_data_reg <= (mode == 2'd1) ? rx_shift_reg[8:1] : rx_shift_reg[7:0];
               rx_ninth_bit_reg <= (mode == 2'd1) ? rx_pin : rx_shift_reg[8];
            end
         end
      end
   end

   // Read data.
   always @* begin
      reg_rdata_out = 8'h00;
      if (reg_rd_in && reg_addr_in == `SP0_ADDR_CONTROL) begin
         reg_rdata_out = {frame_err_detect_enable_in ? frame_error_reg : mode_hi_reg,
                          mode_low_bit_reg, multiproc_enable_reg, rx_enable_reg,
                          tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg,
                          rx_done_flag_reg};
      end else if (reg_rd_in && reg_addr_in == `SP0_ADDR_DATA) begin
         reg_rdata_out = rx_data_reg;
      end
   end
endmodule // sp0_uart

// file: test/sp0_peer.sv
module sp0_peer (
   // Clock.
   input wire logic mclk_in,
   // Line from the port and line to it.
   input wire logic txd_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int bit_clks = 32;
   // The receive line is driven high, so it rests high between frames.
   initial line_out = 1'b1;

   // Start low, data LSB first, then the stop level asked for.
   task automatic send(input logic [8:0] bits, input int n, input logic stop_bit);
      int i;
      @(posedge mclk_in);
      line_out <= 1'b0;
      repeat (bit_clks) @(posedge mclk_in);
      for (i = 0; i < n; i++) begin
         line_out <= bits[i];
         repeat (bit_clks) @(posedge mclk_in);
      end
      line_out <= stop_bit;
      repeat (bit_clks) @(posedge mclk_in);
      line_out <= 1'b1;
   endtask

   // Samples n bits and the stop bit at their middles; returns at mid-stop.
   task automatic recv(input int n, output logic [9:0] bits);
      int i;
      int t;
      bits = 10'h000;
      t = 0;
      while (txd_in && t < 20000) begin
         @(posedge mclk_in);
         t++;
      end
      repeat (bit_clks / 2) @(posedge mclk_in);
      for (i = 0; i <= n; i++) begin
         repeat (bit_clks) @(posedge mclk_in);
         bits[i] = txd_in;
      end
   endtask
endmodule // sp0_peer

// file: test/sp0_uart_chk.sv
module sp0_uart_chk (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Register port.
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   // Pins and status.
   input wire logic rxd_oen_out,
   input wire logic txd_out,
   input wire logic tx_done_flag_out,
   input wire logic rx_done_flag_out,
   input wire logic tx_ready_out
);
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   wire ctl_wr = reg_wr_in && reg_addr_in == 8'h98;
   wire mapped = reg_addr_in == 8'h98 || reg_addr_in == 8'h99;

   a_reset_idle: assert property ($rose(resetn_in) |-> txd_out && rxd_oen_out
      && !tx_done_flag_out && !rx_done_flag_out) else $error("pins or flags not idle after reset");
   a_read_zero: assert property ((!reg_rd_in || !mapped) |-> reg_rdata_out == 8'h00)
      else $error("read data not zero");
   a_read_flags: assert property (reg_rd_in && reg_addr_in == 8'h98
      |-> reg_rdata_out[1:0] == {tx_done_flag_out, rx_done_flag_out})
      else $error("control read disagrees with flags");
   a_tx_sticky: assert property (tx_done_flag_out && !(ctl_wr && !reg_wdata_in[1])
      |=> tx_done_flag_out) else $error("transmit flag lost");
   a_rx_sticky: assert property (rx_done_flag_out && !(ctl_wr && !reg_wdata_in[0])
      |=> rx_done_flag_out) else $error("receive flag lost");
   a_tx_stop: assert property ($rose(tx_done_flag_out) && !$past(ctl_wr)
      |-> ##[0:2] txd_out) else $error("transmit flag not at stop bit");
   a_ready_fall: assert property ($fell(tx_ready_out)
      |-> $past(reg_wr_in && reg_addr_in == 8'h99)) else $error("fifo filled without write");
   a_oen_rest: assert property (rx_done_flag_out [*3] |-> rxd_oen_out)
      else $error("receive pin driven while flag set");

   c_rx_done: cover property ($rose(rx_done_flag_out));
   c_tx_done: cover property ($rose(tx_done_flag_out));
   c_fifo_full: cover property ($fell(tx_ready_out));
endmodule // sp0_uart_chk

bind sp0_uart sp0_uart_chk sp0_uart_chk_i (.mclk_in, .resetn_in, .reg_addr_in, .reg_wr_in,
   .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .rxd_oen_out, .txd_out, .tx_done_flag_out,
   .rx_done_flag_out, .tx_ready_out);

// file: test/test_sp0_uart.sv
`include "sp0_regs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
   $display("Error %s expected %h seen %h", n, e, g); err_total++; end end
module test_sp0_uart;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic frame_err_detect_enable_in = 1'b0;
   logic baud_double_in = 1'b0;
   logic baud_tick_in = 1'b0;
   wire [7:0] reg_rdata_out;
   wire rxd_in, rxd_out, rxd_oen_out, txd_out, peer_line;
   wire tx_done_flag_out, rx_done_flag_out, tx_ready_out;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int i;
   logic [9:0] got;
   logic [7:0] rv;

   always #2.5 mclk_in = ~mclk_in;
   // A tick every second clock gives a 32 clock bit in the variable rate modes.
   always @(posedge mclk_in) baud_tick_in <= ~baud_tick_in;

   sp0_uart sp0_uart_i (.mclk_in, .resetn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
      .reg_wdata_in, .reg_rdata_out, .frame_err_detect_enable_in, .baud_double_in,
      .baud_tick_in, .rxd_in, .rxd_out, .rxd_oen_out, .txd_out, .tx_done_flag_out,
      .rx_done_flag_out, .tx_ready_out);
   sp0_peer sp0_peer_i (.mclk_in, .txd_in(txd_out), .line_out(peer_line));
   assign rxd_in = rxd_oen_out ? peer_line : rxd_out;

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge mclk_in);
      d = reg_rdata_out;
      reg_rd_in <= 1'b0;
   endtask

   task automatic complete_run;
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         complete_run;
      end
   end

   initial begin
      repeat (5) @(posedge mclk_in);
      resetn_in <= 1'b1;
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("control reset", `SP0_CTL_RESET, rv)
      reg_read(8'h9a, rv);
      `CHK("unmapped", 8'h00, rv)
      // Fill the fifo in mode 1 until it refuses, then drain it on the line.
      reg_write(`SP0_ADDR_CONTROL, 8'h50);
      // The first frame starts while the fifo fills, so listen for it meanwhile.
      fork
         for (i = 0; i < 34; i++) reg_write(`SP0_ADDR_DATA, 8'(i * 29 + 7));
         sp0_peer_i.recv(8, got);
      join
      `CHK("fifo full", 1'b0, tx_ready_out)
      `CHK("mode 1 first", {2'b01, 8'h07}, got)
      for (i = 1; i < 33; i++) begin
         sp0_peer_i.recv(8, got);
         `CHK("mode 1 frame", {2'b01, 8'(i * 29 + 7)}, got)
      end
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("tx flag", 8'h52, rv)
      repeat (64) @(posedge mclk_in);
      reg_write(`SP0_ADDR_CONTROL, 8'hc8);
      reg_write(`SP0_ADDR_DATA, 8'h96);
      sp0_peer_i.recv(9, got);
      `CHK("mode 3 ninth", 10'h396, got)
      for (i = 0; i < 2; i++) begin
         repeat (64) @(posedge mclk_in);
         baud_double_in <= i[0];
         sp0_peer_i.bit_clks = i ? 32 : 64;
         reg_write(`SP0_ADDR_CONTROL, 8'h80);
         reg_write(`SP0_ADDR_DATA, 8'h3c + 8'(i));
         sp0_peer_i.recv(9, got);
         `CHK("mode 2 rate", {2'b10, 8'h3c + 8'(i)}, got)
      end
      repeat (128) @(posedge mclk_in);
      baud_double_in <= 1'b0;
      sp0_peer_i.bit_clks = 32;
      reg_write(`SP0_ADDR_CONTROL, 8'h50);
      sp0_peer_i.send(9'h03c, 8, 1'b1);
      `CHK("rx flag", 1'b1, rx_done_flag_out)
      reg_read(`SP0_ADDR_DATA, rv);
      `CHK("rx data", 8'h3c, rv)
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("stop in ninth", 8'h55, rv)
      reg_write(`SP0_ADDR_CONTROL, 8'h50);
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("flag clear", 8'h50, rv)
      reg_write(`SP0_ADDR_CONTROL, 8'h40);
      sp0_peer_i.send(9'h011, 8, 1'b1);
      `CHK("rx disabled", 1'b0, rx_done_flag_out)
      frame_err_detect_enable_in <= 1'b1;
      reg_write(`SP0_ADDR_CONTROL, 8'h70);
      sp0_peer_i.send(9'h022, 8, 1'b0);
      `CHK("bad stop", 1'b0, rx_done_flag_out)
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("frame error", 1'b1, rv[7])
      reg_write(`SP0_ADDR_CONTROL, 8'h70);
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("frame error clear", 1'b0, rv[7])
      frame_err_detect_enable_in <= 1'b0;
      reg_write(`SP0_ADDR_CONTROL, 8'hf0);
      sp0_peer_i.send(9'h0a5, 9, 1'b1);
      `CHK("ninth zero", 1'b0, rx_done_flag_out)
      sp0_peer_i.send(9'h15a, 9, 1'b1);
      `CHK("ninth one", 1'b1, rx_done_flag_out)
      reg_read(`SP0_ADDR_DATA, rv);
      `CHK("mode 3 data", 8'h5a, rv)
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("mode 3 control", 8'hf5, rv)
      resetn_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      resetn_in <= 1'b1;
      reg_read(`SP0_ADDR_CONTROL, rv);
      `CHK("control reset again", `SP0_CTL_RESET, rv)
      complete_run;
   end
endmodule // test_sp0_uart
